// ### rtl/frac_top.sv
// Summary of operation
// R01: opcode 06h sets write enable latch
// R02: opcode 04h clears write enable latch
// R03: protection error blocks 04h; 50h clears both
// R04: 06h/04h run only at exact 8 bits
// R05: opcode on lane 0, 1:0 or 3:0
// R06: extended reads drive lane one; else shared
// R07: chip select high ends read, releases lanes
// R08: 05h and 70h accepted anytime, continuous
// R09: host polls busy before other commands
// R10: nonvolatile read gives zeros after 16 bits
// R11: reserved configuration fields read as ones
// R12: 85h/65h/c8h repeat same byte
// R13: nonvolatile register low byte first
// R14: register writes need latch set
// R15: select rises exactly at data boundary
// R16: wrong boundary discards write, latch kept
// R17: status and nonvolatile writes self-timed
// R18: 01h updates status bits 7:2 only
// R19: protect bit combines with write protect pin
// R20: busy during timed write; latch cleared
// R21: volatile writes immediate, reserved kept
// R22: host sends nonvolatile bytes low first
// R23: protected write keeps latch, flags 1,4
// R24: 50h resets error flags
// R25: partial byte abandons command untouched
`timescale 1ns/1ps
`include "frac_params.svh"

module frac_top #(
    parameter int STATUS_WRITE_NS = 8000,
    parameter int NVCFG_WRITE_NS = 16000
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic chip_select_n,
    input wire logic serial_clock,
    input wire logic [3:0] serial_lane_in,
    output logic [3:0] serial_lane_out,
    output logic [3:0] serial_lane_oe,
    input wire logic write_protect_n
);

    // write durations in clock cycles, rounded up
    localparam int SW_CYC =
        (STATUS_WRITE_NS + `FRAC_CLK_NS - 1) / `FRAC_CLK_NS;
    localparam int NV_CYC = (NVCFG_WRITE_NS + `FRAC_CLK_NS - 1) / `FRAC_CLK_NS;

    logic [6:0] sync1_reg, sync2_reg;
    logic sclk_d_reg, csn_d_reg;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, csn_s, wp_n_s;
    logic [3:0] lanes_s;
    frac_pkg::frac_state_e state_reg;
    frac_pkg::frac_proto_e proto_reg;
    logic [4:0] bit_cnt_reg, step;
    logic [7:0] op_reg, cmd_sr_reg;
    logic [15:0] data_sr_reg;
    logic [4:0] need_bits;
    logic [7:0] sr_reg, fsr_reg, vcr_reg, evcr_reg, ear_reg, sr_pend_reg;
    logic [15:0] nvcr_reg, nv_pend_reg;
    logic busy_reg, busy_nv_reg;
    logic [31:0] timer_reg;
    logic [7:0] out_sr_reg;
    logic [2:0] out_pos_reg;
    logic [1:0] out_byte_reg;
    logic drive_reg;
    logic [7:0] shift_in_byte;
    logic [15:0] shift_in_word;
    logic is_read_op, is_wreg_op, exec_ok;
    logic aw_full_reg, w_full_reg;
    logic [4:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;

    // two-stage synchronisers for every pin input
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 7'h7f;
            sync2_reg <= 7'h7f;
        end else begin
            sync1_reg <= {write_protect_n, chip_select_n, serial_clock,
                          serial_lane_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign lanes_s = sync2_reg[3:0];
    assign csn_s = sync2_reg[5];
    assign wp_n_s = sync2_reg[6];

    // edge detection on synchronised clock and select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sclk_d_reg <= 1'b0;
            csn_d_reg <= 1'b1;
        end else begin
            sclk_d_reg <= sync2_reg[4];
            csn_d_reg <= csn_s;
        end
    end

    assign sclk_rise = sync2_reg[4] & ~sclk_d_reg & ~csn_s;
    assign sclk_fall = ~sync2_reg[4] & sclk_d_reg & ~csn_s;
    assign cs_fall = ~csn_s & csn_d_reg;
    assign cs_rise = csn_s & ~csn_d_reg;

    // R05: lanes per clock by protocol
    always_comb begin
        case (proto_reg)
            frac_pkg::FRAC_DUAL: begin
                step = 5'h02;
                shift_in_byte = {cmd_sr_reg[5:0], lanes_s[1:0]};
                shift_in_word = {data_sr_reg[13:0], lanes_s[1:0]};
            end
            frac_pkg::FRAC_QUAD: begin
                step = 5'h04;
                shift_in_byte = {cmd_sr_reg[3:0], lanes_s};
                shift_in_word = {data_sr_reg[11:0], lanes_s};
            end
            default: begin
                step = 5'h01;
                shift_in_byte = {cmd_sr_reg[6:0], lanes_s[0]};
                shift_in_word = {data_sr_reg[14:0], lanes_s[0]};
            end
        endcase
    end

    // opcode classes and data length
    always_comb begin
        is_read_op = 1'b0;
        is_wreg_op = 1'b1;
        need_bits = `FRAC_BYTE_BITS;
        case (shift_in_byte)
            `FRAC_OP_RDSR, `FRAC_OP_RDFSR, `FRAC_OP_RDNVCR, `FRAC_OP_RDVCR,
            `FRAC_OP_RDEVCR, `FRAC_OP_RDEAR: begin
                is_read_op = 1'b1;
                is_wreg_op = 1'b0;
            end
            `FRAC_OP_WRSR, `FRAC_OP_WRVCR, `FRAC_OP_WREVCR,
            `FRAC_OP_WREAR: begin
                is_wreg_op = 1'b1;
            end
            default: begin
                is_wreg_op = 1'b0;
            end
        endcase
        if (op_reg == `FRAC_OP_WRNVCR) begin
            need_bits = `FRAC_WORD_BITS;
        end
        if (shift_in_byte == `FRAC_OP_WRNVCR) begin
            is_wreg_op = 1'b1;
        end
    end

    // R15: execute only on the exact data boundary
    assign exec_ok = cs_rise && state_reg == frac_pkg::FRAC_WDATA &&
                     bit_cnt_reg == need_bits;

    // link phase tracking
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= frac_pkg::FRAC_IDLE;
            bit_cnt_reg <= 5'h00;
            cmd_sr_reg <= 8'h00;
            data_sr_reg <= 16'h0000;
            op_reg <= 8'h00;
        end else if (csn_s) begin
            // R25: select high drops any partial command
            state_reg <= frac_pkg::FRAC_IDLE;
            bit_cnt_reg <= 5'h00;
        end else if (cs_fall) begin
            state_reg <= frac_pkg::FRAC_CMD;
            bit_cnt_reg <= 5'h00;
        end else if (sclk_rise) begin
            case (state_reg)
                frac_pkg::FRAC_CMD: begin
                    cmd_sr_reg <= shift_in_byte;
                    bit_cnt_reg <= bit_cnt_reg + step;
                    if (bit_cnt_reg + step == `FRAC_BYTE_BITS) begin
                        op_reg <= shift_in_byte;
                        bit_cnt_reg <= 5'h00;
                        // R08: reads taken even while busy
                        if (is_read_op) begin
                            state_reg <= frac_pkg::FRAC_RDATA;
                        end else if (is_wreg_op && !busy_reg) begin
                            state_reg <= frac_pkg::FRAC_WDATA;
                        end else begin
                            state_reg <= frac_pkg::FRAC_OPC;
                        end
                    end
                end
                frac_pkg::FRAC_WDATA: begin
                    data_sr_reg <= shift_in_word;
                    // R16: extra clocks void the write
                    if (bit_cnt_reg == need_bits) begin
                        state_reg <= frac_pkg::FRAC_SKIP;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + step;
                    end
                end
                frac_pkg::FRAC_OPC: begin
                    // R04: clocks past the opcode void it
                    state_reg <= frac_pkg::FRAC_SKIP;
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // read data byte per opcode and byte index
    function automatic logic [7:0] rd_byte(input logic [7:0] op,
                                           input logic [1:0] idx);
        logic [7:0] b;
        b = 8'h00;
        case (op)
            `FRAC_OP_RDSR: b = sr_reg;
            `FRAC_OP_RDFSR: begin
                b = fsr_reg;
                b[`FRAC_FSR_READY] = ~busy_reg;
            end
            // R13: low byte first
            // R10: zeros after sixteen bits
            // R11: reserved fields as ones
            `FRAC_OP_RDNVCR: begin
                if (idx == 2'h0) begin
                    b = nvcr_reg[7:0] | 8'(`FRAC_NVCR_RSVD);
                end else if (idx == 2'h1) begin
                    b = nvcr_reg[15:8] | 8'(`FRAC_NVCR_RSVD >> 8);
                end else begin
                    b = 8'h00;
                end
            end
            // R12: same byte repeats
            `FRAC_OP_RDVCR: b = vcr_reg | `FRAC_VCR_RSVD;
            `FRAC_OP_RDEVCR: b = evcr_reg | `FRAC_EVCR_RSVD;
            `FRAC_OP_RDEAR: b = ear_reg | `FRAC_EAR_RSVD;
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // output shifter on falling serial clock edges
    always_ff @(posedge aclk) begin
        if (!aresetn || csn_s) begin
            // R07: select high stops the output
            out_sr_reg <= 8'h00;
            out_pos_reg <= 3'h0;
            out_byte_reg <= 2'h0;
            drive_reg <= 1'b0;
        end else if (sclk_fall && state_reg == frac_pkg::FRAC_RDATA) begin
            drive_reg <= 1'b1;
            if (out_pos_reg == 3'h0) begin
                // R08: live value reloaded each byte
                out_sr_reg <= rd_byte(op_reg, out_byte_reg);
                if (out_byte_reg != 2'h2) begin
                    out_byte_reg <= out_byte_reg + 2'h1;
                end
            end else begin
                out_sr_reg <= out_sr_reg << step;
            end
            out_pos_reg <= 3'(out_pos_reg + step);
        end
    end

    // R06: lane use for output per protocol
    always_comb begin
        serial_lane_out = 4'h0;
        serial_lane_oe = 4'h0;
        case (proto_reg)
            frac_pkg::FRAC_DUAL: begin
                serial_lane_out[1:0] = out_sr_reg[7:6];
                serial_lane_oe[1:0] = {2{drive_reg}};
            end
            frac_pkg::FRAC_QUAD: begin
                serial_lane_out = out_sr_reg[7:4];
                serial_lane_oe = {4{drive_reg}};
            end
            default: begin
                serial_lane_out[1] = out_sr_reg[7];
                serial_lane_oe[1] = drive_reg;
            end
        endcase
    end

    // command execution and register updates
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sr_reg <= `FRAC_SR_RST;
            fsr_reg <= `FRAC_FSR_RST;
            nvcr_reg <= `FRAC_NVCR_RST;
            vcr_reg <= `FRAC_VCR_RST;
            evcr_reg <= `FRAC_EVCR_RST;
            ear_reg <= `FRAC_EAR_RST;
            sr_pend_reg <= `FRAC_SR_RST;
            nv_pend_reg <= `FRAC_NVCR_RST;
            busy_reg <= 1'b0;
            busy_nv_reg <= 1'b0;
            timer_reg <= 32'h0;
        end else begin
            // R17: self-timed completion
            if (busy_reg) begin
                if (timer_reg == 32'h0) begin
                    // R20: busy clears on completion
                    busy_reg <= 1'b0;
                    sr_reg[`FRAC_SR_WIP] <= 1'b0;
                    if (busy_nv_reg) begin
                        nvcr_reg <= nv_pend_reg;
                    end else begin
                        // R18: only bits 7:2 written
                        sr_reg[7:2] <= sr_pend_reg[7:2];
                    end
                end else begin
                    timer_reg <= timer_reg - 32'h1;
                end
            end
            if (cs_rise && state_reg == frac_pkg::FRAC_OPC && !busy_reg) begin
                case (op_reg)
                    // R01: write enable
                    // R04: exact eight bits only
                    `FRAC_OP_WREN: sr_reg[`FRAC_SR_WEL] <= 1'b1;
                    // R02: write disable
                    // R03: kept while protection error
                    `FRAC_OP_WRDI: begin
                        if (!fsr_reg[`FRAC_FSR_PROT]) begin
                            sr_reg[`FRAC_SR_WEL] <= 1'b0;
                        end
                    end
                    // R24: clear error flags
                    // R03: also clears the latch
                    `FRAC_OP_CLFSR: begin
                        if (fsr_reg[`FRAC_FSR_PROT]) begin
                            sr_reg[`FRAC_SR_WEL] <= 1'b0;
                        end
                        fsr_reg[`FRAC_FSR_PROT] <= 1'b0;
                        fsr_reg[`FRAC_FSR_PROG] <= 1'b0;
                        fsr_reg[`FRAC_FSR_ERASE] <= 1'b0;
                    end
                    default: begin
                        fsr_reg <= fsr_reg;
                    end
                endcase
            end
            // R14: latch must be set
            if (exec_ok && sr_reg[`FRAC_SR_WEL]) begin
                case (op_reg)
                    `FRAC_OP_WRSR: begin
                        // R19: protect bit with pin low
                        // R23: latch stays, flags raised
                        if (sr_reg[`FRAC_SR_SRWD] && !wp_n_s) begin
                            fsr_reg[`FRAC_FSR_PROT] <= 1'b1;
                            fsr_reg[`FRAC_FSR_PROG] <= 1'b1;
                        end else begin
                            sr_pend_reg <= data_sr_reg[7:0] &
                                           `FRAC_SR_SW_MASK;
                            busy_reg <= 1'b1;
                            busy_nv_reg <= 1'b0;
                            timer_reg <= 32'(SW_CYC - 1);
                            // R20: busy shown, latch cleared
                            sr_reg[`FRAC_SR_WIP] <= 1'b1;
                            sr_reg[`FRAC_SR_WEL] <= 1'b0;
                        end
                    end
                    `FRAC_OP_WRNVCR: begin
                        // R22: first byte sent is the low byte
                        nv_pend_reg <= {data_sr_reg[7:0], data_sr_reg[15:8]};
                        busy_reg <= 1'b1;
                        busy_nv_reg <= 1'b1;
                        timer_reg <= 32'(NV_CYC - 1);
                        sr_reg[`FRAC_SR_WIP] <= 1'b1;
                        sr_reg[`FRAC_SR_WEL] <= 1'b0;
                    end
                    // R21: immediate, reserved bits kept
                    `FRAC_OP_WRVCR: begin
                        vcr_reg <= (data_sr_reg[7:0] & ~`FRAC_VCR_RSVD) |
                                   (vcr_reg & `FRAC_VCR_RSVD);
                        sr_reg[`FRAC_SR_WEL] <= 1'b0;
                    end
                    `FRAC_OP_WREVCR: begin
                        evcr_reg <= (data_sr_reg[7:0] & ~`FRAC_EVCR_RSVD) |
                                    (evcr_reg & `FRAC_EVCR_RSVD);
                        sr_reg[`FRAC_SR_WEL] <= 1'b0;
                    end
                    `FRAC_OP_WREAR: begin
                        ear_reg <= data_sr_reg[7:0];
                        sr_reg[`FRAC_SR_WEL] <= 1'b0;
                    end
                    default: begin
                        fsr_reg <= fsr_reg;
                    end
                endcase
            end
        end
    end

    // bus write channel capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 5'h00;
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FRAC_RESP_OKAY;
            proto_reg <= frac_pkg::FRAC_EXT;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (aw_full_reg && w_full_reg && !s_axi_bvalid) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `FRAC_RESP_OKAY;
                case (aw_addr_reg)
                    `FRAC_ADDR_CTRL: begin
                        if (w_strb_reg[0] && w_data_reg[1:0] != 2'b11) begin
                            proto_reg <= frac_pkg::frac_proto_e'(
                                w_data_reg[1:0]);
                        end
                    end
                    `FRAC_ADDR_STATUS, `FRAC_ADDR_FLAG, `FRAC_ADDR_NVCR,
                    `FRAC_ADDR_VCFG: begin
                        s_axi_bresp <= `FRAC_RESP_OKAY;
                    end
                    default: s_axi_bresp <= `FRAC_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_awready = ~aw_full_reg;
    assign s_axi_wready = ~w_full_reg;
    assign s_axi_arready = ~s_axi_rvalid;

    // bus read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `FRAC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `FRAC_RESP_OKAY;
            case (s_axi_araddr)
                `FRAC_ADDR_CTRL: s_axi_rdata <= {30'h0, proto_reg};
                `FRAC_ADDR_STATUS: s_axi_rdata <= {24'h0, sr_reg};
                `FRAC_ADDR_FLAG: begin
                    s_axi_rdata <= {24'h0, ~busy_reg, fsr_reg[6:0]};
                end
                `FRAC_ADDR_NVCR: s_axi_rdata <= {16'h0, nvcr_reg};
                `FRAC_ADDR_VCFG: begin
                    s_axi_rdata <= {8'h0, ear_reg, evcr_reg, vcr_reg};
                end
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= `FRAC_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : frac_top

// ### rtl/frac_params.svh
`ifndef FRAC_PARAMS_SVH
`define FRAC_PARAMS_SVH

// command codes
`define FRAC_OP_WREN 8'h06
`define FRAC_OP_WRDI 8'h04
`define FRAC_OP_RDSR 8'h05
`define FRAC_OP_RDFSR 8'h70
`define FRAC_OP_RDNVCR 8'hb5
`define FRAC_OP_RDVCR 8'h85
`define FRAC_OP_RDEVCR 8'h65
`define FRAC_OP_RDEAR 8'hc8
`define FRAC_OP_WRSR 8'h01
`define FRAC_OP_WRNVCR 8'hb1
`define FRAC_OP_WRVCR 8'h81
`define FRAC_OP_WREVCR 8'h61
`define FRAC_OP_WREAR 8'hc5
`define FRAC_OP_CLFSR 8'h50

// status and flag status bit positions
`define FRAC_SR_WIP 0
`define FRAC_SR_WEL 1
`define FRAC_SR_SRWD 7
`define FRAC_SR_SW_MASK 8'hfc
`define FRAC_FSR_PROT 1
`define FRAC_FSR_PROG 4
`define FRAC_FSR_ERASE 5
`define FRAC_FSR_READY 7

// reserved field masks, read back as ones
`define FRAC_NVCR_RSVD 16'h0010
`define FRAC_VCR_RSVD 8'h04
`define FRAC_EVCR_RSVD 8'h10
`define FRAC_EAR_RSVD 8'h00

// reset values
`define FRAC_SR_RST 8'h00
`define FRAC_FSR_RST 8'h00
`define FRAC_NVCR_RST 16'hffff
`define FRAC_VCR_RST 8'hfb
`define FRAC_EVCR_RST 8'hff
`define FRAC_EAR_RST 8'h00

// bit counts on the link
`define FRAC_BYTE_BITS 5'h08
`define FRAC_WORD_BITS 5'h10

// register bus map
`define FRAC_ADDR_CTRL 5'h00
`define FRAC_ADDR_STATUS 5'h04
`define FRAC_ADDR_FLAG 5'h08
`define FRAC_ADDR_NVCR 5'h0c
`define FRAC_ADDR_VCFG 5'h10
`define FRAC_RESP_OKAY 2'b00
`define FRAC_RESP_SLVERR 2'b10

// clock period in ns
`define FRAC_CLK_NS 4

`endif

// ### rtl/frac_pkg.sv
package frac_pkg;

    // link phases
    typedef enum logic [2:0] {
        FRAC_IDLE = 3'b000,
        FRAC_CMD = 3'b001,
        FRAC_OPC = 3'b010,
        FRAC_WDATA = 3'b011,
        FRAC_RDATA = 3'b100,
        FRAC_SKIP = 3'b101
    } frac_state_e;

    // lane protocol
    typedef enum logic [1:0] {
        FRAC_EXT = 2'b00,
        FRAC_DUAL = 2'b01,
        FRAC_QUAD = 2'b10
    } frac_proto_e;

endpackage : frac_pkg

// ### sim/frac_top_monitor.sv
`timescale 1ns/1ps
module frac_top_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic chip_select_n,
    input wire logic [3:0] serial_lane_oe,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    lanes_released_a: assert property (
        chip_select_n [*6] |-> serial_lane_oe == 4'h0) else $error("held");
    lane_one_used_a: assert property (
        serial_lane_oe[0] |-> serial_lane_oe[1]) else $error("lane one");
    lane_group_a: assert property (
        |serial_lane_oe |-> serial_lane_oe inside {4'h2, 4'h3, 4'hf})
        else $error("lane group");
    drive_selected_a: assert property (
        $rose(|serial_lane_oe) |-> $past(!chip_select_n, 3))
        else $error("drive unselected");
    drive_kept_a: assert property (
        |serial_lane_oe && !chip_select_n |=> |serial_lane_oe)
        else $error("drive dropped");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rd");
    read_once_a: assert property (
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rd twice");
    write_once_a: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("wr twice");
    // main scenarios
    cover property ($rose(|serial_lane_oe));
    cover property ($rose(chip_select_n) && |serial_lane_oe);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule : frac_top_monitor
bind frac_top frac_top_monitor mon (.*);

// ### sim/frac_host_model.sv
`timescale 1ns/1ps
module frac_host_model (
    output logic cs_n,
    output logic sclk,
    output logic [3:0] dq,
    input wire logic [3:0] q
);
    int w = 1;
    // idle: deselected, clock parked low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        dq = 4'h0;
    end
    // msb first on the low lane group, then released lanes toggle
    // select rises right after the requested bit count
    task frame(input logic [31:0] t, input int nt, input int nr,
               output logic [31:0] rx);
        rx = 32'h0;
        #1 cs_n = 1'b0;
        for (int i = 0; i < nt + nr; i += w) begin
            dq = (i < nt) ? 4'((t << i) >> (32 - w)) : ~dq;
            #80 sclk = 1'b1;
            if (i >= nt) rx = (rx << w) |
                32'((w == 1) ? {3'h0, q[1]} : q & 4'((1 << w) - 1));
            #80 sclk = 1'b0;
        end
        #80 cs_n = 1'b1;
        dq = ~dq;
        #79;
    endtask : frame
endmodule : frac_host_model

// ### sim/tb_flash_register_access_commands.sv
`timescale 1ns/1ps
`include "frac_params.svh"
module tb_flash_register_access_commands;
    logic aclk = 1'b0, aresetn = 1'b0, write_protect_n = 1'b1;
    logic [4:0] s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rx, v, rd;
    logic [3:0] s_axi_wstrb = 4'hf, serial_lane_in, serial_lane_out, hs;
    logic [3:0] serial_lane_oe, host_dq;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, chip_select_n, serial_clock;
    int num_errors = 0, n_tests = 0, seed = 80, k;
    always #2 aclk = ~aclk;
    // lane level: device where it drives, host elsewhere
    assign serial_lane_in = (serial_lane_oe & serial_lane_out) |
                            (~serial_lane_oe & host_dq);
    frac_top #(.STATUS_WRITE_NS(400), .NVCFG_WRITE_NS(400)) uut (.*);
    frac_host_model host (.cs_n(chip_select_n), .sclk(serial_clock),
                          .dq(host_dq), .q(serial_lane_in));
    function logic [7:0] vcr_exp(input logic [7:0] d);
        return (d & ~`FRAC_VCR_RSVD) | `FRAC_VCR_RSVD;
    endfunction : vcr_exp
    task cmp(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    task results;
        if (num_errors == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    task axw(input logic [4:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 60 && (k == 0 || s_axi_bready); k++) begin
            @(negedge aclk);
            hs = {s_axi_awready, s_axi_wready, s_axi_bvalid};
            if (hs[0]) rs = s_axi_bresp;
            @(posedge aclk);
            if (hs[2]) s_axi_awvalid <= 1'b0;
            if (hs[1]) s_axi_wvalid <= 1'b0;
            if (hs[0]) s_axi_bready <= 1'b0;
        end
        if (k >= 60) num_errors++;
        if (k >= 60) results();
    endtask : axw
    task axr(input logic [4:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 60 && (k == 0 || s_axi_rready); k++) begin
            @(negedge aclk);
            hs = {s_axi_arready, s_axi_rvalid};
            if (hs[0]) {rd, rs} = {s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (hs[1]) s_axi_arvalid <= 1'b0;
            if (hs[0]) s_axi_rready <= 1'b0;
        end
        if (k >= 60) num_errors++;
        if (k >= 60) results();
        cmp(rd, e);
    endtask : axr
    // main sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        axr(`FRAC_ADDR_FLAG, 32'h80);
        axr(`FRAC_ADDR_NVCR, 32'hffff);
        axr(5'h14, 32'h0);
        cmp(rs, `FRAC_RESP_SLVERR);
        axw(5'h14, 32'h0);
        cmp(rs, `FRAC_RESP_SLVERR);
        host.frame(32'h06000000, 7, 0, rx);
        host.frame(32'h06000000, 9, 0, rx);
        host.frame(32'h01fc0000, 16, 0, rx);
        axr(`FRAC_ADDR_STATUS, 32'h0);
        for (int p = 0; p < 3; p++) begin
            axw(`FRAC_ADDR_CTRL, 32'(p));
            host.w = 1 << p;
            host.frame(32'h06000000, 8, 0, rx);
            host.frame(32'h05000000, 8, 16, rx);
            cmp(rx, 32'h0202);
            host.frame(32'h04000000, 8, 0, rx);
            axr(`FRAC_ADDR_STATUS, 32'h0);
        end
        axw(`FRAC_ADDR_CTRL, 32'h0);
        host.w = 1;
        host.frame(32'h06000000, 8, 0, rx);
        host.frame(32'h01fc0000, 24, 0, rx);
        axr(`FRAC_ADDR_STATUS, 32'h02);
        v = $random(seed) & 32'h7f;
        host.frame({8'h01, v[7:0], 16'h0}, 16, 0, rx);
        axr(`FRAC_ADDR_STATUS, 32'h1);
        #400;
        axr(`FRAC_ADDR_STATUS, v & 32'hfc);
        host.frame(32'h06000000, 8, 0, rx);
        v = $random(seed);
        host.frame({8'hb1, v[7:0], v[15:8], 8'h0}, 24, 0, rx);
        #400;
        host.frame(32'hb5000000, 8, 24, rx);
        v[15:0] = v[15:0] | `FRAC_NVCR_RSVD;
        cmp(rx, {8'h0, v[7:0], v[15:8], 8'h0});
        host.frame(32'h06000000, 8, 0, rx);
        v = $random(seed);
        host.frame({8'h81, v[7:0], 16'h0}, 16, 0, rx);
        host.frame(32'h85000000, 8, 12, rx);
        v[7:0] = vcr_exp(v[7:0]);
        cmp(rx, {20'h0, v[7:0], v[7:4]});
        host.frame(32'h06000000, 8, 0, rx);
        host.frame(32'h01800000, 16, 0, rx);
        #400;
        @(posedge aclk);
        write_protect_n <= 1'b0;
        host.frame(32'h06000000, 8, 0, rx);
        host.frame(32'h01000000, 16, 0, rx);
        axr(`FRAC_ADDR_FLAG, 32'h92);
        host.frame(32'h04000000, 8, 0, rx);
        axr(`FRAC_ADDR_STATUS, 32'h82);
        host.frame(32'h50000000, 8, 0, rx);
        axr(`FRAC_ADDR_FLAG, 32'h80);
        axr(`FRAC_ADDR_STATUS, 32'h80);
        results();
    end
endmodule : tb_flash_register_access_commands
